// ### rtl/rpc_ctrl.sv
/*
 Reset pin sequencer, mode latch, wait recovery, interrupt pin sense select and
 pulse accumulator edge counter, all in one bus-clock domain.
 Assumes pins arrive asynchronous and the open-drain reset wire is resolved outside.
*/
`timescale 1ns/1ps
`include "rpc_defs.svh"
module rpc_ctrl
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reset_pin_n_in,
   output logic reset_pin_n_out,
   output logic reset_pin_n_oe,
   input wire logic internal_reset_req,
   input wire logic [1:0] mode_pins,
   input wire logic wait_enter,
   input wire logic wake_event,
   input wire logic irq_pin_n,
   input wire logic irq_edge_select,
   input wire logic irq_ack,
   input wire logic pacc_pin,
   output logic core_reset,
   output logic reset_external,
   output logic reset_done,
   output logic [1:0] mode_latched,
   output logic core_clk_run,
   output logic irq_pending,
   output logic [`RPC_PACC_WIDTH-1:0] pacc_count
);
   rpc_pkg::rpc_state_t state;
   rpc_pkg::rpc_state_t next_state;
   rpc_pkg::rpc_wait_t wstate;
   rpc_pkg::rpc_wait_t next_wstate;
   logic reset_sync;
   logic irq_sync;
   logic pacc_sync;
   logic [1:0] mode_s1;
   logic [1:0] mode_s2;
   logic [2:0] cnt;
   logic [2:0] wcnt;
   logic irq_prev;
   logic pacc_prev;
   logic int_req;

   // Idle levels per pin: reset and irq rest high, accumulator input rests low,
   // so no false edge follows reset
   localparam logic [2:0] SYNC_INIT = 3'h3;
   logic [2:0] pin_raw;
   logic [2:0] pin_clean;

   assign pin_raw = {pacc_pin, irq_pin_n, reset_pin_n_in};

   // Every pin synchronised before any recognition
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_sync
         rpc_sync #(.INIT(SYNC_INIT[gi])) u_sync
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_in(pin_raw[gi]),
            .pin_sync(pin_clean[gi])
         );
      end
   endgenerate

   assign reset_sync = pin_clean[0];
   assign irq_sync = pin_clean[1];
   assign pacc_sync = pin_clean[2];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mode_s1 <= `RPC_MODE_RESET;
         mode_s2 <= `RPC_MODE_RESET;
      end
      else
      begin
         mode_s1 <= mode_pins;
         mode_s2 <= mode_s1;
      end
   end

   // State test shared by the sequencer decodes and the pin driver
   function automatic logic in_state(input rpc_pkg::rpc_state_t cur,
      input rpc_pkg::rpc_state_t want);
      return cur == want;
   endfunction

   // Last cycle of a phase that runs len cycles from a zero count
   function automatic logic count_end(input logic [2:0] count, input logic [2:0] len);
      return count == len - 3'h1;
   endfunction

   wire pin_low = !reset_sync;
   wire start_seq = in_state(state, rpc_pkg::RPC_IDLE) && (pin_low || internal_reset_req);
   wire drive_last = in_state(state, rpc_pkg::RPC_DRIVE) &&
      count_end(cnt, `RPC_DRIVE_CYCLES);
   // Pin level two cycles after release reaches the synchronised copy only
   // after the synchroniser latency; sampling earlier sees our own drive
   wire settle_last = in_state(state, rpc_pkg::RPC_SETTLE) &&
      count_end(cnt, `RPC_SAMPLE_DELAY + `RPC_SYNC_LATENCY);
   // Held until pin seen high, so a long outside pulse keeps the core in reset
   wire hold_done = in_state(state, rpc_pkg::RPC_HOLD) && !pin_low;

   always_comb
   begin
      next_state = state;
      case (state)
         rpc_pkg::RPC_IDLE:
            if (start_seq)
               next_state = rpc_pkg::RPC_DRIVE;
         rpc_pkg::RPC_DRIVE:
            if (drive_last)
               next_state = rpc_pkg::RPC_SETTLE;
         rpc_pkg::RPC_SETTLE:
            if (settle_last)
               next_state = rpc_pkg::RPC_HOLD;
         rpc_pkg::RPC_HOLD:
            if (hold_done)
               next_state = rpc_pkg::RPC_IDLE;
         default:
            next_state = rpc_pkg::RPC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= rpc_pkg::RPC_IDLE;
         cnt <= 3'h0;
         int_req <= 1'b0;
         reset_external <= 1'b0;
         reset_done <= 1'b0;
         mode_latched <= `RPC_MODE_RESET;
      end
      else
      begin
         state <= next_state;
         cnt <= (drive_last || settle_last || start_seq) ? 3'h0 : cnt + 3'h1;
         reset_done <= hold_done;
         if (start_seq)
            int_req <= internal_reset_req && !pin_low;
         // Pin still low two cycles after release means outside source
         if (settle_last)
            reset_external <= pin_low || !int_req;
         // Mode latched at release; outside must meet setup
         if (hold_done)
            mode_latched <= mode_s2;
      end
   end

   assign reset_pin_n_out = 1'b0;
   assign reset_pin_n_oe = in_state(state, rpc_pkg::RPC_DRIVE);
   assign core_reset = !in_state(state, rpc_pkg::RPC_IDLE);

   // Wait mode: wake or reset restarts the clocks within the bound
   wire wake_hit = wake_event || core_reset;
   // One recovery cycle is spent entering the wake state
   wire wake_last = (wstate == rpc_pkg::RPC_WAKE) &&
      count_end(wcnt, `RPC_WAIT_RECOVERY_CYCLES - 3'h1);

   always_comb
   begin
      next_wstate = wstate;
      case (wstate)
         rpc_pkg::RPC_RUN:
            if (wait_enter && !core_reset)
               next_wstate = rpc_pkg::RPC_WAIT;
         rpc_pkg::RPC_WAIT:
            if (wake_hit)
               next_wstate = rpc_pkg::RPC_WAKE;
         rpc_pkg::RPC_WAKE:
            if (wake_last)
               next_wstate = rpc_pkg::RPC_RUN;
         default:
            next_wstate = rpc_pkg::RPC_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wstate <= rpc_pkg::RPC_RUN;
         wcnt <= 3'h0;
      end
      else
      begin
         wstate <= next_wstate;
         wcnt <= (wstate == rpc_pkg::RPC_WAKE) ? wcnt + 3'h1 : 3'h0;
      end
   end

   assign core_clk_run = (wstate == rpc_pkg::RPC_RUN);

   // Interrupt pin: falling edge latched, or level followed
   wire irq_fall = irq_prev && !irq_sync;
   wire irq_level = !irq_sync;

   // Edge only counted after a full cycle between samples, capping at half rate
   wire pacc_rise = pacc_sync && !pacc_prev;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irq_prev <= 1'b1;
         pacc_prev <= 1'b0;
         irq_pending <= 1'b0;
         pacc_count <= '0;
      end
      else
      begin
         irq_prev <= irq_sync;
         pacc_prev <= pacc_sync;
         if (irq_edge_select)
            irq_pending <= irq_fall || (irq_pending && !irq_ack);
         else
            irq_pending <= irq_level;
         if (pacc_rise)
            pacc_count <= pacc_count + 8'h01;
      end
   end
endmodule

// ### rtl/rpc_defs.svh
/*
 Constants for the reset pin and control timing block: sequence counts, mode latch
 window and rate limits, all in bus-clock cycles.
 Assumes the includer runs on a single 40 MHz clock that stands for the bus clock.
*/
// Behaviour
// - Reset recognised on first low sampled cycle
// - Drive reset four cycles, release, sample two later
// - Wake from wait within four cycles
// - Reset also ends wait mode
// - Interrupt pin edge when select one, else level
// - Pulse accumulator counts at most half rate
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

`define RPC_DRIVE_CYCLES 3'h4
`define RPC_SAMPLE_DELAY 3'h2
`define RPC_SYNC_LATENCY 3'h2
`define RPC_EXT_MIN_CYCLES 4'h8
`define RPC_MODE_SETUP_CYCLES 2'h2
`define RPC_WAIT_RECOVERY_CYCLES 3'h4
`define RPC_MODE_RESET 2'h0
`define RPC_PACC_WIDTH 8

`endif

// ### rtl/rpc_pkg.sv
/*
 Types for the reset pin and control timing block.
 Assumes the includer has read rpc_defs.svh where constants are needed.
*/
package rpc_pkg;
   typedef enum logic [2:0] {
      RPC_IDLE,
      RPC_DRIVE,
      RPC_SETTLE,
      RPC_HOLD
   } rpc_state_t;

   typedef enum logic [1:0] {
      RPC_RUN,
      RPC_WAIT,
      RPC_WAKE
   } rpc_wait_t;
endpackage

// ### rtl/rpc_sync.sv
/*
 Two flip-flop synchroniser for one pin level.
 Assumes a single clock and a synchronous active-high reset; reset value is a parameter.
*/
`timescale 1ns/1ps
module rpc_sync
#(
   parameter logic INIT = 1'b1
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pin_in,
   output logic pin_sync
);
   logic stage1;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage1 <= INIT;
         pin_sync <= INIT;
      end
      else
      begin
         stage1 <= pin_in;
         pin_sync <= stage1;
      end
   end
endmodule

// ### verification/rpc_ctrl_assertions.sv
/* Port checker for rpc_ctrl.
 Assumes it is bound onto rpc_ctrl, one clock, sync reset. */
`timescale 1ns/1ps
`include "rpc_defs.svh"
module rpc_ctrl_checker
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reset_pin_n_in,
   input wire logic reset_pin_n_oe,
   input wire logic wake_event,
   input wire logic core_reset,
   input wire logic reset_external,
   input wire logic reset_done,
   input wire logic core_clk_run,
   input wire logic irq_edge_select,
   input wire logic irq_ack,
   input wire logic irq_pending,
   input wire logic [`RPC_PACC_WIDTH-1:0] pacc_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_low; !reset_pin_n_in [*2]; endsequence
   sequence s_drive; reset_pin_n_oe [*4] ##1 !reset_pin_n_oe; endsequence
   property p_take;
      $fell(reset_pin_n_in) && !core_reset ##1 s_low |=> reset_pin_n_oe;
   endproperty
   a_take: assert property (p_take) else $error("pin low not taken");
   property p_drive; $rose(reset_pin_n_oe) |-> s_drive; endproperty
   a_drive: assert property (p_drive) else $error("drive length");
   property p_oe; reset_pin_n_oe |-> core_reset; endproperty
   a_oe: assert property (p_oe) else $error("drive outside reset");
   property p_ext;
      $fell(reset_pin_n_oe) ##1 !reset_pin_n_in |-> ##3 reset_external;
   endproperty
   a_ext: assert property (p_ext) else $error("source sample");
   property p_done; reset_done |-> !core_reset ##1 !reset_done; endproperty
   a_done: assert property (p_done) else $error("done pulse");
   property p_wake; !core_clk_run && wake_event |-> ##[1:4] core_clk_run; endproperty
   a_wake: assert property (p_wake) else $error("wake late");
   property p_rwake; !core_clk_run && core_reset |-> ##[1:4] core_clk_run; endproperty
   a_rwake: assert property (p_rwake) else $error("reset wake late");
   property p_pacc; $changed(pacc_count) |-> pacc_count == $past(pacc_count) + 8'h01; endproperty
   a_pacc: assert property (p_pacc) else $error("count step");
   property p_irq; irq_edge_select && irq_pending && !irq_ack |=> irq_pending; endproperty
   a_irq: assert property (p_irq) else $error("edge irq lost");
endmodule
bind rpc_ctrl rpc_ctrl_checker i_chk(.clk, .sys_rst, .reset_pin_n_in, .reset_pin_n_oe,
   .wake_event, .core_reset, .reset_external, .reset_done, .core_clk_run,
   .irq_edge_select, .irq_ack, .irq_pending, .pacc_count);

// ### verification/rpc_partner.sv
/* Outside reset source on the open-drain reset wire.
 Assumes a pull-up: the wire reads high unless a party pulls it. */
`timescale 1ns/1ps
module rpc_partner
(
   input wire logic clk,
   input wire logic start,
   input wire logic dev_oe,
   output logic pin_n
);
   logic [3:0] hold = 4'h0;
   // Twelve cycles, above the eight the vector needs
   always_ff @(posedge clk)
   begin
      if (start)
         hold <= 4'hc;
      else if (hold != 4'h0)
         hold <= hold - 4'h1;
   end
   assign pin_n = !(dev_oe || hold != 4'h0);
endmodule

// ### verification/rpc_ctrl_tb.sv
/* Self-checking bench for rpc_ctrl.
 Assumes rpc_partner holds the reset wire for outside resets. */
`timescale 1ns/1ps
module rpc_ctrl_tb;
   logic clk = 1'b0, sys_rst = 1'b1, start = 1'b0, internal_reset_req = 1'b0;
   logic wait_enter = 1'b0, wake_event = 1'b0, irq_pin_n = 1'b1, irq_edge_select = 1'b0;
   logic irq_ack = 1'b0, pacc_pin = 1'b0;
   logic [1:0] mode_pins = 2'h0;
   wire reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, core_reset, reset_external;
   wire reset_done, core_clk_run, irq_pending;
   wire [1:0] mode_latched;
   wire [7:0] pacc_count;
   int fails = 0, samples_checked = 0;
   always #12.5 clk = ~clk;
   rpc_partner i_far(.clk, .start, .dev_oe(reset_pin_n_oe), .pin_n(reset_pin_n_in));
   rpc_ctrl i_dut(.clk, .sys_rst, .reset_pin_n_in, .reset_pin_n_out, .reset_pin_n_oe,
      .internal_reset_req, .mode_pins, .wait_enter, .wake_event, .irq_pin_n, .irq_edge_select,
      .irq_ack, .pacc_pin, .core_reset, .reset_external, .reset_done, .mode_latched,
      .core_clk_run, .irq_pending, .pacc_count);
   task complete_run;
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Counts own drive cycles; bounded so a stuck sequence ends the run
   task wait_done(output int n);
      n = 0;
      for (int k = 0; reset_done !== 1'b1; k++)
      begin
         if (k == 60)
         begin
            fails++;
            complete_run();
         end
         n += int'(reset_pin_n_oe === 1'b1);
         cyc(1);
      end
   endtask
   task t_reset(input logic ext, input logic [1:0] m);
      int n;
      mode_pins = m;
      cyc(3);
      start = ext;
      internal_reset_req = !ext;
      cyc(1);
      start = 1'b0;
      internal_reset_req = 1'b0;
      wait_done(n);
      chk("drive", 8'h04, 8'(n));
      chk("source", 8'(ext), 8'(reset_external));
      chk("mode", 8'(m), 8'(mode_latched));
      chk("core_reset", 8'h00, 8'(core_reset));
      chk("pin_out", 8'h00, 8'(reset_pin_n_out));
      cyc(1);
   endtask
   task t_wait(input logic by_rst);
      int n;
      wait_enter = 1'b1;
      cyc(1);
      wait_enter = 1'b0;
      cyc(1);
      chk("sleep", 8'h00, 8'(core_clk_run));
      wake_event = !by_rst;
      internal_reset_req = by_rst;
      cyc(1);
      wake_event = 1'b0;
      internal_reset_req = 1'b0;
      cyc(4);
      chk("run", 8'h01, 8'(core_clk_run));
      if (by_rst)
         wait_done(n);
   endtask
   task t_irq;
      irq_pin_n = 1'b0;
      cyc(4);
      chk("level", 8'h01, 8'(irq_pending));
      irq_pin_n = 1'b1;
      irq_edge_select = 1'b1;
      irq_ack = 1'b1;
      cyc(1);
      irq_ack = 1'b0;
      cyc(3);
      chk("idle", 8'h00, 8'(irq_pending));
      irq_pin_n = 1'b0;
      cyc(2);
      irq_pin_n = 1'b1;
      cyc(4);
      chk("edge", 8'h01, 8'(irq_pending));
      irq_ack = 1'b1;
      cyc(1);
      irq_ack = 1'b0;
      chk("ack", 8'h00, 8'(irq_pending));
   endtask
   task t_pacc;
      repeat (5)
      begin
         pacc_pin = 1'b1;
         cyc(2);
         pacc_pin = 1'b0;
         cyc(2);
      end
      cyc(3);
      chk("pacc", 8'h05, pacc_count);
   endtask
   initial
   begin
      cyc(3);
      sys_rst = 1'b0;
      t_pacc;
      t_irq;
      t_reset(1'b0, 2'h2);
      t_reset(1'b1, 2'h1);
      t_wait(1'b0);
      t_wait(1'b1);
      complete_run();
   end
endmodule
